// ==== asrx_pkg.sv ====
// Constants, register map and types for the asynchronous serial receiver.
package asrx_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_BAUD     = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_DATA     = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CTRL = 8'h18;
  // Control register bit positions.
  localparam int CB_PORT_ON  = 0;
  localparam int CB_SYNC     = 1;
  localparam int CB_RX_ON    = 2;
  localparam int CB_NINE     = 3;
  localparam int CB_ADDR_DET = 4;
  localparam int CB_FAST     = 5;
  localparam int CB_WIDE     = 6;
  localparam int CB_IRQ_ON   = 7;
  localparam int CB_IRQ_PRIO = 8;
  localparam int CTRL_W   = 9;
  // Interrupt control register bit positions.
  localparam int IB_GLOBAL = 0;
  localparam int IB_PERIPH = 1;
  // Status register bit positions.
  localparam int SB_NINTH = 0;
  localparam int SB_FERR  = 1;
  localparam int SB_OERR  = 2;
  localparam int SB_FULL  = 3;
  localparam int SB_BUSY  = 4;
  // Sticky event bit positions.
  localparam int EB_DONE = 0;
  localparam int EB_FERR = 1;
  localparam int EB_OERR = 2;
  localparam int EV_W    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [15:0]       BAUD_RST = 16'h0000;
  localparam logic [EV_W-1:0]   MASK_RST = 3'h0;
  localparam logic [3:0]        OVS_LAST = 4'hf;
  localparam logic [3:0]        START_MID = 4'h7;
  localparam logic [3:0]        VOTE_A   = 4'hd;
  localparam logic [3:0]        VOTE_B   = 4'he;
  localparam logic [2:0]        LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    ASRX_IDLE  = 3'b000,
    ASRX_START = 3'b001,
    ASRX_DATA  = 3'b011,
    ASRX_NINTH = 3'b010,
    ASRX_STOP  = 3'b110
  } asrx_state_t;
endpackage

// ==== asrx_receiver.sv ====
// Asynchronous serial receiver with APB register access and interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module asrx_receiver (
  input  wire logic                        ref_clk,      // System clock, 100 MHz.
  input  wire logic                        nrst,         // Asynchronous reset, low.
  input  wire logic                        psel,         // APB select.
  input  wire logic                        penable,      // APB enable.
  input  wire logic                        pwrite,       // APB write.
  input  wire logic [asrx_pkg::ADDR_W-1:0] paddr,        // APB byte address.
  input  wire logic [31:0]                 pwdata,       // APB write data.
  output logic      [31:0]                 prdata,       // APB read data.
  output logic                             pready,       // APB ready.
  output logic                             pslverr,      // APB error, unmapped.
  input  wire logic                        rx_pin,       // Serial receive line.
  output logic                             irq,          // Masked sticky events.
  output logic                             rx_irq_high,  // Receive irq, high level.
  output logic                             rx_irq_low    // Receive irq, low level.
);
  import asrx_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       baud;
  logic [1:0]        irq_control_reg;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;
  logic [2:0]        rx_sync;
  logic              rx_s;
  logic [17:0]       tick_cnt;
  logic [17:0]       period;
  logic              sample_tick;
  asrx_state_t       rx_state;
  logic [3:0]        tcnt;
  logic [2:0]        bidx;
  logic [7:0]        shreg;
  logic              va;
  logic              vb;
  logic              maj;
  logic              ninth_rx;
  logic              done_evt;
  logic              done_ninth;
  logic              done_stop;
  logic [7:0]        done_data;
  logic [7:0]        rx_data_buffer;
  logic              rx_ninth;
  logic              rx_complete_flag;
  logic              ferr;
  logic              oerr;
  logic              rx_active;
  logic              addr_mode;
  logic              accept;
  logic              apb_fin;
  logic              apb_wr;
  logic              data_read;
  logic              stat_read;
  logic              mapped;
  logic [31:0]       next_rdata;
  logic [EV_W-1:0]   ev_set;
  logic [15:0]       div_n;
  logic [17:0]       div_p1;

  assign rx_active = ctrl[CB_PORT_ON] & ~ctrl[CB_SYNC] & ctrl[CB_RX_ON];
  assign addr_mode = ctrl[CB_NINE] & ctrl[CB_ADDR_DET];
  assign accept    = ~addr_mode | done_ninth;

  // APB: one wait state so that every answer comes from a flip-flop.
  assign apb_fin   = psel & penable & pready;
  assign apb_wr    = apb_fin & pwrite & ~pslverr;
  assign data_read = apb_fin & ~pwrite & (paddr == OFS_DATA);
  assign stat_read = apb_fin & ~pwrite & (paddr == OFS_IRQ_STAT);

  always_comb begin
    mapped     = 1'b1;
    next_rdata = 32'h0;
    case (paddr)
      OFS_CTRL:     next_rdata = {23'h0, ctrl};
      OFS_BAUD:     next_rdata = {16'h0, baud};
      OFS_STATUS:   next_rdata = {27'h0, (rx_state != ASRX_IDLE), rx_complete_flag,
                                  oerr, ferr, rx_ninth};
      OFS_DATA:     next_rdata = {24'h0, rx_data_buffer};
      OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      OFS_IRQ_CTRL: next_rdata = {30'h0, irq_control_reg};
      default:      mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0 : next_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl            <= CTRL_RST;
      baud            <= BAUD_RST;
      irq_mask        <= MASK_RST;
      irq_control_reg <= 2'h0;
    end else if (apb_wr) begin
      case (paddr)
        OFS_CTRL:     ctrl            <= pwdata[CTRL_W-1:0];
        OFS_BAUD:     baud            <= pwdata[15:0];
        OFS_IRQ_MASK: irq_mask        <= pwdata[EV_W-1:0];
        OFS_IRQ_CTRL: irq_control_reg <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // Three-stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sync <= 3'h7;
      rx_s    <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_pin};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_s <= rx_sync[2];
      end
    end
  end

  // divisor and scaling
  // The fastest setting gives four cycles per bit per unit of divisor, which
  // cannot be split sixteen ways, so the sample tick is floored at one cycle.
  always_comb begin
    div_n  = ctrl[CB_WIDE] ? baud : {8'h0, baud[7:0]};
    div_p1 = {2'b00, div_n} + 18'h1;
    case ({ctrl[CB_WIDE], ctrl[CB_FAST]})
      2'b00:   period = {div_p1[15:0], 2'b00};
      2'b11:   period = (div_p1[17:2] == 16'h0) ? 18'h1 : {2'b00, div_p1[17:2]};
      default: period = div_p1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt    <= 18'h0;
      sample_tick <= 1'b0;
    end else if (!rx_active || tick_cnt >= period - 18'h1) begin
      tick_cnt    <= 18'h0;
      sample_tick <= rx_active;
    end else begin
      tick_cnt    <= tick_cnt + 18'h1;
      sample_tick <= 1'b0;
    end
  end

  // Three-sample vote around the bit centre rejects single-tick line noise.
  assign maj = (va & vb) | (va & rx_s) | (vb & rx_s);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state   <= ASRX_IDLE;
      tcnt       <= 4'h0;
      bidx       <= 3'h0;
      shreg      <= 8'h0;
      va         <= 1'b1;
      vb         <= 1'b1;
      ninth_rx   <= 1'b0;
      done_evt   <= 1'b0;
      done_ninth <= 1'b0;
      done_stop  <= 1'b0;
      done_data  <= 8'h0;
    end else if (!rx_active) begin
      rx_state <= ASRX_IDLE;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (sample_tick) begin
        tcnt <= tcnt + 4'h1;
        if (tcnt == VOTE_A) begin
          va <= rx_s;
        end
        if (tcnt == VOTE_B) begin
          vb <= rx_s;
        end
        case (rx_state)
          ASRX_IDLE: begin
            tcnt <= 4'h0;
            if (!rx_s) begin
              rx_state <= ASRX_START;
            end
          end
          ASRX_START: begin
            if (tcnt == START_MID) begin
              tcnt     <= 4'h0;
              bidx     <= 3'h0;
              rx_state <= rx_s ? ASRX_IDLE : ASRX_DATA;
            end
          end
          ASRX_DATA: begin
            if (tcnt == OVS_LAST) begin
              shreg <= {maj, shreg[7:1]};
              bidx  <= bidx + 3'h1;
              if (bidx == LAST_BIT) begin
                rx_state <= ctrl[CB_NINE] ? ASRX_NINTH : ASRX_STOP;
                ninth_rx <= 1'b0;
              end
            end
          end
          ASRX_NINTH: begin
            if (tcnt == OVS_LAST) begin
              ninth_rx <= maj;
              rx_state <= ASRX_STOP;
            end
          end
          ASRX_STOP: begin
            if (tcnt == OVS_LAST) begin
              done_evt   <= 1'b1;
              done_stop  <= maj;
              done_ninth <= ninth_rx;
              done_data  <= shreg;
              rx_state   <= ASRX_IDLE;
            end
          end
          default: rx_state <= ASRX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_data_buffer   <= 8'h0;
      rx_ninth         <= 1'b0;
      rx_complete_flag <= 1'b0;
    end else if (done_evt && accept && (!rx_complete_flag || data_read)) begin
      rx_data_buffer   <= done_data;
      rx_ninth         <= done_ninth;
      rx_complete_flag <= 1'b1;
    end else if (data_read) begin
      rx_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ferr <= 1'b0;
      oerr <= 1'b0;
    end else if (!ctrl[CB_RX_ON]) begin
      ferr <= 1'b0;
      oerr <= 1'b0;
    end else if (done_evt && accept) begin
      if (!rx_complete_flag || data_read) begin
        ferr <= ~done_stop;
      end else begin
        oerr <= 1'b1;
      end
    end
  end

  assign ev_set[EB_DONE] = done_evt & accept & (~rx_complete_flag | data_read);
  assign ev_set[EB_FERR] = ev_set[EB_DONE] & ~done_stop;
  assign ev_set[EB_OERR] = done_evt & accept & rx_complete_flag & ~data_read;

  // Read of the event register clears only what was returned; new events win.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
    end else if (stat_read) begin
      irq_stat <= (irq_stat & ~prdata[EV_W-1:0]) | ev_set;
    end else begin
      irq_stat <= irq_stat | ev_set;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq         <= 1'b0;
      rx_irq_high <= 1'b0;
      rx_irq_low  <= 1'b0;
    end else begin
      irq         <= |(irq_stat & irq_mask);
      rx_irq_high <= rx_complete_flag & ctrl[CB_IRQ_ON] & irq_control_reg[IB_GLOBAL]
                     & irq_control_reg[IB_PERIPH] & ctrl[CB_IRQ_PRIO];
      rx_irq_low  <= rx_complete_flag & ctrl[CB_IRQ_ON] & irq_control_reg[IB_GLOBAL]
                     & irq_control_reg[IB_PERIPH] & ~ctrl[CB_IRQ_PRIO];
    end
  end

  default clocking asrx_cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_irq_follows: assert property ((|(irq_stat & irq_mask)) |=> irq)
    else $error("irq did not follow masked event");
  a_rx_irq_gate: assert property (
      rx_irq_high |-> $past(irq_control_reg[IB_GLOBAL] && irq_control_reg[IB_PERIPH]))
    else $error("receive irq without global enables");
  a_prio_route: assert property (
      (rx_complete_flag && ctrl[CB_IRQ_ON] && irq_control_reg == 2'h3 && !ctrl[CB_IRQ_PRIO])
      |=> rx_irq_low && !rx_irq_high)
    else $error("low priority irq misrouted");
  a_disabled_idle: assert property (!rx_active |=> rx_state == ASRX_IDLE)
    else $error("receiver busy while disabled");
  a_off_clears_err: assert property (!ctrl[CB_RX_ON] |=> !ferr && !oerr)
    else $error("errors survive receive disable");
  a_addr_discard: assert property (
      (done_evt && addr_mode && !done_ninth && !rx_complete_flag) |=> !rx_complete_flag)
    else $error("data frame kept in address mode");
  a_frame_loads: assert property (
      (done_evt && !addr_mode && !rx_complete_flag) |=> rx_complete_flag
      && rx_data_buffer == $past(done_data))
    else $error("frame not buffered");
  a_tick_gap: assert property (
      (sample_tick && period > 18'h1 && $stable(period)) |=> !sample_tick)
    else $error("sample ticks too close");
  a_shift_once: assert property (
      (rx_state == ASRX_DATA && $changed(shreg)) |=> $stable(shreg)[*8])
    else $error("shifter moved twice in a bit");
  a_apb_wait: assert property ((psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer timing broken");

  c_frame: cover property (done_evt && accept);
  c_overrun: cover property (ev_set[EB_OERR]);
  c_addr_drop: cover property (done_evt && addr_mode && !done_ninth);
  c_unmapped: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ==== asrx_tx_model.sv ====
// Remote serial transmitter model that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module asrx_tx_model (
  input  wire logic ref_clk, // Bench clock.
  output logic      line     // Serial line, idle high.
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic use9, input logic b9,
                      input logic stp, input int cyc);
    logic [10:0] f;
    int          n;
    f = {stp, b9, d, 1'b0};
    n = use9 ? 11 : 10;
    if (!use9) begin
      f[9] = stp;
    end
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (cyc) @(posedge ref_clk);
    end
    // A low stop bit is released to idle high for one cycle, so that a following
    // frame never drives the line twice in one time step.
    if (!stp) begin
      line <= 1'b1;
      @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== test_asrx_receiver.sv ====
// Self-checking bench for the asynchronous serial receiver.
`timescale 1ns/1ps
`default_nettype none
module test_asrx_receiver;
  import asrx_pkg::*;
  logic        ref_clk = 1'b0;
  logic        nrst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        irq, rx_irq_high, rx_irq_low;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  wire         rx_line;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          q[$];
  int          m_on = 0, m_adr = 0, m_full = 0, m_oerr = 0, m_ferr = 0, m_nin = 0, m_ev = 0;
  int          m_cyc = 16;
  localparam int BASE = (1 << CB_PORT_ON) | (1 << CB_RX_ON) | (1 << CB_FAST) | (1 << CB_IRQ_ON);

  always #5 ref_clk = ~ref_clk;

  asrx_receiver asrx_receiver_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_line), .irq(irq),
    .rx_irq_high(rx_irq_high), .rx_irq_low(rx_irq_low));
  asrx_tx_model asrx_tx_model_i (.ref_clk(ref_clk), .line(rx_line));

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input int v);
    apb(1'b1, OFS_CTRL, v);
    m_on = v[CB_PORT_ON] && !v[CB_SYNC] && v[CB_RX_ON];
    m_adr = v[CB_NINE] && v[CB_ADDR_DET];
    if (!v[CB_RX_ON]) begin
      m_oerr = 0;
      m_ferr = 0;
    end
  endtask

  task automatic frame(input int d, input logic use9, input logic b9, input logic stp);
    logic acc;
    acc = m_on && !(m_adr && !b9);
    asrx_tx_model_i.send(d[7:0], use9, b9, stp, m_cyc);
    if (acc && m_full) begin
      m_oerr = 1;
      m_ev |= 4;
    end else if (acc) begin
      q.push_back(d & 8'hff);
      m_full = 1;
      m_ferr = !stp;
      m_nin = b9 & use9;
      m_ev |= stp ? 1 : 3;
    end
  endtask

  task automatic wait_full;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rdata[SB_FULL] !== 1'b1 && n < 30);
    if (rdata[SB_FULL] !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic st;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", (m_full << SB_FULL) | (m_oerr << SB_OERR) | (m_ferr << SB_FERR) | m_nin, rdata);
  endtask

  task automatic take;
    apb(1'b0, OFS_DATA, 32'h0);
    chk("data", q.pop_front(), rdata);
    m_full = 0;
  endtask

  task automatic ev;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("events", m_ev, rdata);
    m_ev = 0;
  endtask

  task automatic pins(input logic e_irq, input logic e_hi, input logic e_lo);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_pin("irq", e_irq, irq);
    chk_pin("rx_irq_high", e_hi, rx_irq_high);
    chk_pin("rx_irq_low", e_lo, rx_irq_low);
  endtask

  initial begin
    int d;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    nrst = 1'b0;
    void'($urandom(32'h0c06c1e5));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, rdata);
    apb(1'b1, OFS_BAUD, 32'habcd1234);
    apb(1'b0, OFS_BAUD, 32'h0);
    chk("baud", 32'h1234, rdata);
    apb(1'b1, OFS_BAUD, 32'h0);
    apb(1'b1, 8'h1c, 32'hffff);
    chk_pin("pslverr", 1'b1, rerr);
    apb(1'b1, OFS_IRQ_CTRL, 32'h3);
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    ctl(BASE & ~(1 << CB_RX_ON));
    frame($urandom, 0, 0, 1);
    ctl(BASE | (1 << CB_SYNC));
    frame($urandom, 0, 0, 1);
    st();
    for (int k = 0; k < 2; k++) begin
      ctl(BASE | (k << CB_IRQ_PRIO));
      frame($urandom, 0, 0, 1);
      wait_full();
      pins(1'b1, k == 1, k == 0);
      take();
      ev();
      pins(1'b0, 1'b0, 1'b0);
    end
    // Every divisor mode; the high divisor byte only counts in 16-bit mode.
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_BAUD, (k == 2) ? 32'h1 : ((k == 3) ? 32'h7 : 32'h100));
      ctl((BASE & ~(1 << CB_FAST)) | ((k == 0 || k == 3) ? (1 << CB_FAST) : 0)
          | ((k >= 2) ? (1 << CB_WIDE) : 0));
      m_cyc = (k == 1) ? 64 : ((k == 0) ? 16 : 32);
      frame($urandom, 0, 0, 1);
      wait_full();
      take();
      ev();
    end
    apb(1'b1, OFS_BAUD, 32'h0);
    m_cyc = 16;
    ctl(BASE | (1 << CB_NINE) | (1 << CB_ADDR_DET));
    frame($urandom, 1, 0, 1);
    st();
    frame($urandom, 1, 1, 1);
    wait_full();
    st();
    take();
    ctl(BASE | (1 << CB_NINE));
    frame($urandom, 1, 0, 1);
    wait_full();
    take();
    ev();
    apb(1'b1, OFS_IRQ_CTRL, 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    ctl(BASE);
    frame($urandom, 0, 0, 1);
    wait_full();
    pins(1'b0, 1'b0, 1'b0);
    take();
    ev();
    apb(1'b1, OFS_IRQ_CTRL, 32'h3);
    d = $urandom | 32'h80;
    frame(d, 0, 0, 0);
    wait_full();
    st();
    take();
    ev();
    ctl(BASE & ~(1 << CB_RX_ON));
    st();
    ctl(BASE);
    frame($urandom, 0, 0, 1);
    frame($urandom, 0, 0, 1);
    wait_full();
    st();
    take();
    ev();
    ctl(BASE & ~(1 << CB_RX_ON));
    st();
    // A mid-run reset must bring the interrupt control register and interrupt pins back to reset values.
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, OFS_IRQ_CTRL, 32'h0);
    chk("irq_ctrl", 32'h0, rdata);
    pins(1'b0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
